// *** rtl/ulpics_codec.sv ***
// ULPI command decoder and status byte sender, device end of the bus
// Operation
// R1 - Link idles the bus at 00h when it has nothing to send.
// R2 - Transmit command is code 01; payload 000000 means raw data with no PID.
// R3 - Raw transmit starts on the line only after the following data byte is taken.
// R4 - Transmit with payload 00xxxx sends packet with PID from the low four bits.
// R5 - Code 10 payload 101111 is extended write: 8-bit address, then data follow.
// R6 - Other code 10 payloads write the register at the six-bit payload address.
// R7 - Code 11 payload 101111 is extended read: an 8-bit address follows.
// R8 - Other code 11 payloads read the register at the six-bit payload address.
// R9 - Status goes out by raising dir and placing one status byte on the bus.
// R10 - A new status byte is sent whenever any status field changes.
// R11 - Link accepts status bytes at any time, including back to back.
// R12 - Status byte may be dropped on low-power exit if the cause has vanished.
// R13 - Status bits 1:0 carry line state, bit 0 to bit 0.
// R14 - Status bits 3:2 carry bus voltage code, bits 5:4 receive event code.
// R15 - Status bit 6 follows the cable id pin.
// R16 - Status bit 7 flags enabled b-session-valid rise or fall events.
// R17 - Any data line change sends a status byte with the new line state.
// R18 - Dual-role link picks line state meaning by host or peripheral mode.
// R19 - Next is raised once a nonzero command byte is taken.
// R20 - While dir is high, next stays low and the bus carries status values; on a register read the code puts the read data there too.
// R21 - Event code: 00 idle, 01 active, 11 active with error, 10 disconnect.
// R22 - Voltage code: 00 below end, 01 end to valid, 10 to a-valid, 11 above.
module ulpics_codec (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       nrst,
    // ULPI pins, sampled through two flops
    input  wire logic                       ulpiClk,
    input  wire logic                       ulpiStp,
    input  wire logic [7:0]                 ulpiDataIn,
    output logic      [7:0]                 ulpiDataOut,
    output logic                            ulpiDataOe,
    output logic                            ulpiDir,
    output logic                            ulpiNxt,
    // Analog front end status and controls
    input  wire ulpics_pkg::ulpics_status_t status,
    input  wire logic                       lowPower,
    input  wire logic                       bvRiseEn,
    input  wire logic                       bvFallEn,
    // Register file side
    input  wire logic [7:0]                 regRdData,
    output ulpics_pkg::ulpics_reg_t         regReq,
    // Transmit side
    output ulpics_pkg::ulpics_tx_t          txReq
);

    ulpics_pkg::ulpics_state_t q;
    ulpics_pkg::ulpics_state_t d;
    ulpics_pkg::ulpics_pins_t  pinsIn;
    logic [7:0]                rxByte;
    logic [7:0]                busIn;
    logic                      linkEdge;
    logic                      sendNeeded;
    logic                      newAlt;

    // ************************************************************
    // Input gathering and status encoding
    // ************************************************************
    // Pins are bundled so that one two-stage synchroniser covers all of them
    assign pinsIn = '{linkClk: ulpiClk, stp: ulpiStp, data: ulpiDataIn, lowPower: lowPower,
                      bvRiseEn: bvRiseEn, bvFallEn: bvFallEn, status: status};
    assign busIn    = q.s2.data;
    assign linkEdge = q.s2.linkClk && !q.clkPrev;

    ulpics_rxcmd_enc u_enc (
        .clk                    (clk),
        .nrst                   (nrst),
        .status                 (q.s2.status),
        .alternateInterruptFlag (q.altPending),
        .rxByte                 (rxByte)
    );

    // Bit 7 is excluded from the compare: it is a one-shot flag, not a level
    assign sendNeeded = q.forceSend || q.altPending || (rxByte[6:0] != q.lastSent); // see R10 R17
    assign newAlt = (q.s2.status.bvalid && !q.bvPrev && q.s2.bvRiseEn) ||
                    (!q.s2.status.bvalid && q.bvPrev && q.s2.bvFallEn);          // see R16

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        d              = q;
        d.s1           = pinsIn;
        d.s2           = q.s1;
        d.clkPrev      = q.s2.linkClk;
        d.bvPrev       = q.s2.status.bvalid;
        d.tx.start     = 1'b0;
        d.tx.byteValid = 1'b0;
        d.tx.done      = 1'b0;
        d.rg.write     = 1'b0;
        d.rg.read      = 1'b0;
        if (linkEdge) begin
            case (q.state)
                ulpics_pkg::S_IDLE: begin
                    if (q.s2.stp) begin
                        d.state = ulpics_pkg::S_IDLE;
                    end else if (busIn != ulpics_pkg::BUS_IDLE) begin // see R1
                        d.cmd = busIn;
                        d.nxt = 1'b1;                                 // see R19
                        case (busIn[7:6])
                            ulpics_pkg::CMD_TX: d.state = ulpics_pkg::S_TXCMD;
                            ulpics_pkg::CMD_WR: d.state = ulpics_pkg::S_WRCMD;
                            default:            d.state = ulpics_pkg::S_RDCMD;
                        endcase
                    end else if (sendNeeded && !q.s2.lowPower) begin
                        // Held off in low power; on exit only a real difference is sent
                        d.dir        = 1'b1;                          // see R9 R12
                        d.dataOut    = rxByte;
                        d.lastSent   = rxByte[6:0];
                        d.forceSend  = 1'b0;
                        d.altPending = 1'b0;
                        d.state      = ulpics_pkg::S_RXSEND;
                    end
                end
                ulpics_pkg::S_TXCMD: begin
                    d.tx.noPid   = (q.cmd[5:0] == ulpics_pkg::PAYLOAD_RAW); // see R2
                    d.tx.pid     = q.cmd[3:0];
                    d.txStarted  = 1'b0;
                    d.state      = ulpics_pkg::S_TX;
                    if (q.s2.stp) begin
                        d.tx.done = 1'b1;
                        d.nxt     = 1'b0;
                        d.state   = ulpics_pkg::S_IDLE;
                    end else if (q.cmd[5:0] != ulpics_pkg::PAYLOAD_RAW) begin
                        d.tx.start = 1'b1;                            // see R4
                        d.txStarted = 1'b1;
                    end
                end
                ulpics_pkg::S_TX: begin
                    if (q.s2.stp) begin
                        d.tx.done = 1'b1;
                        d.nxt     = 1'b0;
                        d.state   = ulpics_pkg::S_IDLE;
                    end else begin
                        d.tx.byteValid = 1'b1;
                        d.tx.byteData  = busIn;
                        d.tx.start     = !q.txStarted;                // see R3
                        d.txStarted    = 1'b1;
                    end
                end
                ulpics_pkg::S_WRCMD: begin
                    if (q.cmd[5:0] == ulpics_pkg::PAYLOAD_EXT) begin
                        d.state = ulpics_pkg::S_WRADDR;               // see R5
                    end else begin
                        d.rg.addr = {2'h0, q.cmd[5:0]};               // see R6
                        d.state   = ulpics_pkg::S_WRDATA;
                    end
                end
                ulpics_pkg::S_WRADDR: begin
                    d.rg.addr = busIn;                                // see R5
                    d.state   = ulpics_pkg::S_WRDATA;
                end
                ulpics_pkg::S_WRDATA: begin
                    d.rg.wdata = busIn;
                    d.rg.write = 1'b1;
                    d.nxt      = 1'b0;
                    d.state    = ulpics_pkg::S_IDLE;
                end
                ulpics_pkg::S_RDCMD: begin
                    if (q.cmd[5:0] == ulpics_pkg::PAYLOAD_EXT) begin
                        d.state = ulpics_pkg::S_RDADDR;               // see R7
                    end else begin
                        d.rg.addr  = {2'h0, q.cmd[5:0]};              // see R8
                        d.rg.read  = 1'b1;
                        d.nxt      = 1'b0;
                        d.dir      = 1'b1;
                        d.dataOut  = rxByte;                          // see R20
                        d.state    = ulpics_pkg::S_RDTURN;
                    end
                end
                ulpics_pkg::S_RDADDR: begin
                    d.rg.addr = busIn;                                // see R7
                    d.rg.read = 1'b1;
                    d.nxt     = 1'b0;
                    d.dir     = 1'b1;
                    d.dataOut = rxByte;
                    d.state   = ulpics_pkg::S_RDTURN;
                end
                ulpics_pkg::S_RDTURN: begin
                    d.dataOut = regRdData;
                    d.state   = ulpics_pkg::S_RDDATA;
                end
                ulpics_pkg::S_RXSEND: begin
                    if (sendNeeded && !q.s2.lowPower) begin
                        // Back-to-back byte when status moved again
                        d.dataOut    = rxByte;                        // see R10
                        d.lastSent   = rxByte[6:0];
                        d.forceSend  = 1'b0;
                        d.altPending = 1'b0;
                    end else begin
                        d.dir   = 1'b0;
                        d.state = ulpics_pkg::S_IDLE;
                    end
                end
                default: begin
                    d.dir   = 1'b0;
                    d.nxt   = 1'b0;
                    d.state = ulpics_pkg::S_IDLE;
                end
            endcase
        end
        // A new event outranks the clear done by sending the byte
        if (newAlt) begin
            d.altPending = 1'b1;                                      // see R16
        end
    end

    // State register; a status byte is owed right after reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            q           <= '0;
            q.state     <= ulpics_pkg::S_IDLE;
            q.forceSend <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign ulpiDir     = q.dir;
    assign ulpiNxt     = q.nxt;
    assign ulpiDataOut = q.dataOut;
    assign ulpiDataOe  = q.dir;                                       // see R20
    assign regReq      = q.rg;
    assign txReq       = q.tx;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Two link periods plus synchroniser latency, so one missed edge still passes
    localparam int RxWait = ulpics_pkg::RX_WAIT_CYC;

    sequence cmdSeen;
        linkEdge && q.state == ulpics_pkg::S_IDLE && !q.s2.stp && busIn != ulpics_pkg::BUS_IDLE;
    endsequence
    sequence changePending;
        q.state == ulpics_pkg::S_IDLE && sendNeeded && !q.s2.lowPower && !q.s2.stp;
    endsequence

    AST_NXT_AFTER_CMD: assert property (cmdSeen |=> ulpiNxt && !ulpiDir) // see R19
        else $error("next not raised after command");
    AST_DIR_NXT_LOW: assert property (ulpiDir |-> !ulpiNxt && ulpiDataOe) // see R20
        else $error("next high or bus undriven while dir high");
    AST_RXCMD_SENT: assert property ( // see R10
            changePending |-> ##[0:RxWait]
            (ulpiDir || q.state != ulpics_pkg::S_IDLE || !sendNeeded))
        else $error("status change not reported");
    AST_RXCMD_DATA: assert property ( // see R9
            changePending ##0 (linkEdge && busIn == ulpics_pkg::BUS_IDLE) |=>
            ulpiDir && ulpiDataOut == $past(rxByte))
        else $error("status byte not on bus");
    AST_PID_START: assert property ( // see R4
            txReq.start && !txReq.noPid |->
            txReq.pid == q.cmd[3:0] && $past(q.state) == ulpics_pkg::S_TXCMD)
        else $error("pid transmit started wrongly");
    AST_RAW_START: assert property (txReq.start && txReq.noPid |-> txReq.byteValid) // see R3
        else $error("raw transmit started before data byte");
    AST_REGW_ADDR: assert property ( // see R6
            regReq.write && q.cmd[5:0] != ulpics_pkg::PAYLOAD_EXT |->
            regReq.addr == {2'h0, q.cmd[5:0]})
        else $error("immediate write address wrong");
    AST_REGR_ADDR: assert property ( // see R8
            regReq.read && q.cmd[5:0] != ulpics_pkg::PAYLOAD_EXT |->
            regReq.addr == {2'h0, q.cmd[5:0]} ##1 ulpiDir)
        else $error("immediate read address wrong");
    AST_ALT_SET: assert property ( // see R16
            $rose(q.s2.status.bvalid) && q.s2.bvRiseEn |=> q.altPending)
        else $error("b-valid rise not flagged");

endmodule : ulpics_codec

// *** rtl/ulpics_pkg.sv ***
// Shared constants and carrier types for the ULPI command and status codec
package ulpics_pkg;

    // ************************************************************
    // Command byte layout
    // ************************************************************
    localparam logic [1:0] CMD_IDLE     = 2'h0;
    localparam logic [1:0] CMD_TX       = 2'h1;
    localparam logic [1:0] CMD_WR       = 2'h2;
    localparam logic [1:0] CMD_RD       = 2'h3;
    localparam logic [5:0] PAYLOAD_EXT  = 6'h2f;
    localparam logic [5:0] PAYLOAD_RAW  = 6'h00;
    localparam logic [7:0] BUS_IDLE     = 8'h00;

    // ************************************************************
    // Status byte layout and codes
    // ************************************************************
    localparam int         LS_LSB       = 0;
    localparam int         VBUS_LSB     = 2;
    localparam int         EVT_LSB      = 4;
    localparam int         ID_BIT       = 6;
    localparam int         ALT_BIT      = 7;
    localparam logic [1:0] VBUS_LOW     = 2'h0;
    localparam logic [1:0] VBUS_END     = 2'h1;
    localparam logic [1:0] VBUS_SESS    = 2'h2;
    localparam logic [1:0] VBUS_AVLD    = 2'h3;
    localparam logic [1:0] EVT_IDLE     = 2'h0;
    localparam logic [1:0] EVT_ACTIVE   = 2'h1;
    localparam logic [1:0] EVT_ERROR    = 2'h3;
    localparam logic [1:0] EVT_DISCON   = 2'h2;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int         SYNC_STAGES  = 2;
    localparam int         RX_WAIT_CYC  = 20;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic [1:0] lineState;
        logic       sessEnd;
        logic       sessVld;
        logic       aVbusVld;
        logic       rxActive;
        logic       rxError;
        logic       hostDisconnect;
        logic       idPin;
        logic       bvalid;
    } ulpics_status_t;

    typedef struct packed {
        logic           linkClk;
        logic           stp;
        logic [7:0]     data;
        logic           lowPower;
        logic           bvRiseEn;
        logic           bvFallEn;
        ulpics_status_t status;
    } ulpics_pins_t;

    typedef struct packed {
        logic       start;
        logic       noPid;
        logic [3:0] pid;
        logic       byteValid;
        logic [7:0] byteData;
        logic       done;
    } ulpics_tx_t;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ulpics_reg_t;

    typedef enum logic [10:0] {
        S_IDLE   = 11'h001,
        S_TXCMD  = 11'h002,
        S_TX     = 11'h004,
        S_WRCMD  = 11'h008,
        S_WRADDR = 11'h010,
        S_WRDATA = 11'h020,
        S_RDCMD  = 11'h040,
        S_RDADDR = 11'h080,
        S_RDTURN = 11'h100,
        S_RDDATA = 11'h200,
        S_RXSEND = 11'h400
    } ulpics_fsm_t;

    typedef struct packed {
        ulpics_pins_t s1;
        ulpics_pins_t s2;
        logic         clkPrev;
        logic         bvPrev;
        ulpics_fsm_t  state;
        logic [7:0]   cmd;
        logic [6:0]   lastSent;
        logic         forceSend;
        logic         altPending;
        logic         txStarted;
        logic         dir;
        logic         nxt;
        logic [7:0]   dataOut;
        ulpics_tx_t   tx;
        ulpics_reg_t  rg;
    } ulpics_state_t;

endpackage : ulpics_pkg

// *** rtl/ulpics_rxcmd_enc.sv ***
// Status byte encoder: packs line state, bus voltage, receive event, cable id and alt flag
module ulpics_rxcmd_enc (
    // Clock and reset, used by the checks only
    input  wire logic                   clk,
    input  wire logic                   nrst,
    // Synchronised status
    input  wire ulpics_pkg::ulpics_status_t status,
    input  wire logic                   alternateInterruptFlag,
    // Encoded byte
    output logic [7:0]                  rxByte
);

    // ************************************************************
    // Encoders
    // ************************************************************
    // Highest threshold wins, so a comparator glitch low never masks a valid level
    function automatic logic [1:0] vbusCode(input ulpics_pkg::ulpics_status_t s);
        if (s.aVbusVld)     vbusCode = ulpics_pkg::VBUS_AVLD;
        else if (s.sessVld) vbusCode = ulpics_pkg::VBUS_SESS;
        else if (s.sessEnd) vbusCode = ulpics_pkg::VBUS_LOW;
        else                vbusCode = ulpics_pkg::VBUS_END;
    endfunction : vbusCode

    // Disconnect overrides any receive activity
    function automatic logic [1:0] eventCode(input ulpics_pkg::ulpics_status_t s);
        if (s.hostDisconnect) eventCode = ulpics_pkg::EVT_DISCON;
        else if (!s.rxActive) eventCode = ulpics_pkg::EVT_IDLE;
        else if (s.rxError)   eventCode = ulpics_pkg::EVT_ERROR;
        else                  eventCode = ulpics_pkg::EVT_ACTIVE;
    endfunction : eventCode

    // Byte assembly
    always_comb begin
        rxByte = '0;
        rxByte[ulpics_pkg::LS_LSB+:2]   = status.lineState;        // see R13 R17
        rxByte[ulpics_pkg::VBUS_LSB+:2] = vbusCode(status);        // see R14 R22
        rxByte[ulpics_pkg::EVT_LSB+:2]  = eventCode(status);       // see R14 R21
        rxByte[ulpics_pkg::ID_BIT]      = status.idPin;            // see R15
        rxByte[ulpics_pkg::ALT_BIT]     = alternateInterruptFlag;  // see R16
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_LS_BITS: assert property ( // see R13
            rxByte[0] == status.lineState[0] && rxByte[1] == status.lineState[1])
        else $error("line state bits misplaced");
    AST_ID_BIT: assert property (rxByte[6] == status.idPin) // see R15
        else $error("cable id bit wrong");
    AST_VBUS_LOW: assert property ( // see R22
            status.sessEnd && !status.sessVld && !status.aVbusVld |-> rxByte[3:2] == 2'h0)
        else $error("vbus below session end not coded 00");
    AST_VBUS_AVLD: assert property (status.aVbusVld |-> rxByte[3:2] == 2'h3) // see R14
        else $error("vbus a-valid not coded 11");
    AST_EVT_CODE: assert property ( // see R21
            status.rxActive && status.rxError && !status.hostDisconnect |-> rxByte[5:4] == 2'h3)
        else $error("receive error not coded 11");

endmodule : ulpics_rxcmd_enc

// *** verification/test_ulpi_command_status_codec.sv ***
// Self-checking bench for the ULPI command and status codec
module test_ulpi_command_status_codec;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ulpiClk, ulpiStp, ulpiDataOe, ulpiDir, ulpiNxt, lowPower, bvRiseEn, bvFallEn;
    logic [7:0] linkData, bus, ulpiDataOut, regRdData, rdLog, ea, d;
    logic [15:0] wrLog;
    logic [31:0] txLog;
    logic [5:0] stLog, a;
    logic [3:0] p;
    ulpics_pkg::ulpics_status_t st;
    ulpics_pkg::ulpics_reg_t regReq;
    ulpics_pkg::ulpics_tx_t txReq;
    int nMismatch = 0;
    int nChecks = 0;
    int doneCnt = 0;
    int cnt0;
    // ****************
    // Design and partner
    // ****************
    assign bus = ulpiDataOe ? ulpiDataOut : linkData;
    ulpics_codec uut (.clk(clk), .nrst(nrst), .ulpiClk(ulpiClk), .ulpiStp(ulpiStp),
        .ulpiDataIn(bus), .ulpiDataOut(ulpiDataOut), .ulpiDataOe(ulpiDataOe), .ulpiDir(ulpiDir),
        .ulpiNxt(ulpiNxt), .status(st), .lowPower(lowPower), .bvRiseEn(bvRiseEn),
        .bvFallEn(bvFallEn), .regRdData(regRdData), .regReq(regReq), .txReq(txReq));
    ulpics_link_model lnk (.clk(clk), .ulpiClk(ulpiClk), .ulpiStp(ulpiStp),
        .linkData(linkData), .busData(bus), .ulpiDir(ulpiDir), .ulpiNxt(ulpiNxt));
    // Logs the last write, read and start request and the last four transmit bytes on the user side; counts done
    always @(posedge clk) begin
        if (regReq.write === 1'b1) wrLog <= {regReq.addr, regReq.wdata};
        if (regReq.read === 1'b1) rdLog <= regReq.addr;
        if (txReq.start === 1'b1) stLog <= {txReq.byteValid, txReq.noPid, txReq.pid};
        if (txReq.byteValid === 1'b1) txLog <= {txLog[23:0], txReq.byteData};
        if (txReq.done === 1'b1) doneCnt <= doneCnt + 1;
    end
    // Builds front end levels for given codes; r fills the don't-care inputs
    function automatic ulpics_pkg::ulpics_status_t mkStatus(input logic [1:0] v, e, ls,
            input logic id, input logic [3:0] r);
        ulpics_pkg::ulpics_status_t s;
        s.lineState = ls;
        s.sessEnd = (v == 2'h0) | (v[1] & r[0]);
        s.sessVld = v[1] & (v[0] ? r[1] : 1'b1);
        s.aVbusVld = (v == 2'h3);
        s.rxActive = (e == 2'h2) ? r[2] : e[0];
        s.rxError = (e == 2'h2) ? r[3] : (e == 2'h3);
        s.hostDisconnect = (e == 2'h2);
        s.idPin = id;
        s.bvalid = st.bvalid;
        return s;
    endfunction : mkStatus
    // Expected status byte, assembled from the field codes the stimulus asked for
    function automatic logic [7:0] expStatus(input logic alt, id, input logic [1:0] e, v, ls);
        return {alt, id, e, v, ls};
    endfunction : expStatus
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check
    task automatic waitLink(input int n);
        repeat (n) @(posedge ulpiClk);
        @(negedge clk);
    endtask : waitLink
    task automatic giveVerdict();
        if (nMismatch == 0 && nChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : giveVerdict
    // ****************
    // Tests
    // ****************
    initial begin
        forever #25 clk = ~clk;
    end
    // Whole run needs about 60 us; a hang is cut off well past that
    initial begin
        #500000;
        nMismatch++;
        giveVerdict();
    end
    initial begin
        void'($urandom(15232));
        {lowPower, bvRiseEn, bvFallEn, regRdData, st} = 21'h0;
        st = mkStatus(2'h1, 2'h0, 2'h0, 1'b1, 4'h0);
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        waitLink(4);
        check(lnk.lastRx, expStatus(1'b0, 1'b1, 2'h0, 2'h1, 2'h0));
        // Every voltage and event code, line state always moving
        for (int i = 0; i < 16; i++) begin
            cnt0 = lnk.rxCnt;
            st = mkStatus(i[1:0], i[3:2], st.lineState + 2'h1, 1'($urandom), 4'($urandom));
            waitLink(4);
            check(lnk.rxCnt - cnt0, 1);
            check(lnk.lastRx,
                expStatus(1'b0, st.idPin, i[3:2], i[1:0], st.lineState));
        end
        // Alt flag on the enabled edge only
        for (int j = 0; j < 2; j++) begin
            bvRiseEn = !j[0];
            bvFallEn = j[0];
            waitLink(2);
            for (int k = 0; k < 2; k++) begin
                cnt0 = lnk.rxCnt;
                st.bvalid = !st.bvalid;
                waitLink(4);
                check(lnk.rxCnt - cnt0, 32'(k == j));
                if (k == j) check(lnk.lastRx[7], 1'b1);
            end
        end
        // A change undone inside low power leaves nothing to report
        cnt0 = lnk.rxCnt;
        lowPower = 1'b1;
        waitLink(1);
        st.lineState = ~st.lineState;
        waitLink(2);
        st.lineState = ~st.lineState;
        waitLink(2);
        lowPower = 1'b0;
        waitLink(4);
        check(lnk.rxCnt - cnt0, 0);
        // Register writes and reads, immediate and extended
        a = 6'($urandom_range(0, 46));
        d = 8'($urandom);
        ea = 8'($urandom);
        regRdData = 8'($urandom);
        lnk.send(2, {d, 2'h2, a}, 1'b0);
        waitLink(3);
        check(wrLog, {2'h0, a, d});
        check(lnk.nxtWait, 1);
        lnk.send(3, {d, ea, 8'haf}, 1'b0);
        waitLink(3);
        check(wrLog, {ea, d});
        lnk.send(1, {2'h3, a}, 1'b1);
        waitLink(5);
        check(rdLog, {2'h0, a});
        check(lnk.lastRx, regRdData);
        lnk.send(2, {ea, 8'hef}, 1'b1);
        waitLink(5);
        check(rdLog, ea);
        check(lnk.lastRx, regRdData);
        // Packet with identifier, then raw data
        p = 4'($urandom_range(1, 15));
        lnk.send(3, {ea, d, 4'h4, p}, 1'b0);
        waitLink(3);
        check({stLog, txLog[15:0]}, {2'h0, p, d, ea});
        lnk.send(3, {d, ea, 8'h40}, 1'b0);
        waitLink(3);
        check({stLog[5:4], txLog[15:0]}, {2'h3, ea, d});
        check(doneCnt, 2);
        giveVerdict();
    end
endmodule : test_ulpi_command_status_codec

// *** verification/ulpics_link_model.sv ***
// Link controller model: free link clock, command sender, status byte logger
module ulpics_link_model (
    // Clock
    input  wire logic       clk,
    output logic            ulpiClk,
    // Bus
    output logic            ulpiStp,
    output logic [7:0]      linkData,
    input  wire logic [7:0] busData,
    input  wire logic       ulpiDir,
    input  wire logic       ulpiNxt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] held;
    logic [7:0] lastRx;
    int         rxCnt = 0;
    int         nxtWait = 0; // Link edges waited for next on the last command
    // Released bus shows the inverse, so a stale value cannot pass for data
    assign linkData = ulpiDir ? ~held : held;
    // Link clock runs free at 8 clk per period, edges on clk falling edge
    initial begin
        ulpiClk = 1'b0;
        ulpiStp = 1'b0;
        held = 8'h00;
        forever begin
            repeat (4) @(negedge clk);
            ulpiClk = ~ulpiClk;
        end
    end
    // Every status byte is taken, single or back to back
    always @(posedge ulpiClk) begin
        if (ulpiDir === 1'b1) begin
            lastRx <= busData; // Line state kept raw for either port mode
            rxCnt <= rxCnt + 1;
        end
    end
    // Sends n bytes, low byte first; the command stands until next is seen
    task automatic send(input int n, input logic [31:0] b, input logic rd);
        int k;
        @(negedge ulpiClk);
        held = b[7:0];
        k = 0;
        @(posedge ulpiClk);
        while (ulpiNxt !== 1'b1 && k < 8) begin
            @(posedge ulpiClk);
            k++;
        end
        nxtWait = k;
        for (int i = 1; i < n; i++) begin
            @(negedge ulpiClk);
            held = b[8*i+:8];
            @(posedge ulpiClk);
        end
        @(negedge ulpiClk);
        held = 8'h00;
        ulpiStp = !rd;
        @(negedge ulpiClk);
        ulpiStp = 1'b0;
    endtask : send
endmodule : ulpics_link_model
